/* verilog/sfx_pkg.sv */
// sfx_pkg: word codes, field positions and reset values for the synthesizer
// fraction extension and fastlock register bank.
// assumes 24-bit serial words whose low four bits select the register.
package sfx_pkg;

  // word geometry
  localparam int WORD_W = 24;
  localparam int CODE_W = 4;
  localparam int LO_W   = 12;
  localparam int EXT_W  = 10;
  localparam int FRAC_W = 22;

  // register select codes
  localparam logic [3:0] CODE_MAIN     = 4'h0;
  localparam logic [3:0] CODE_DEN_LO   = 4'h1;
  localparam logic [3:0] CODE_PWR      = 4'h3;
  localparam logic [3:0] CODE_CFG      = 4'h9;
  localparam logic [3:0] CODE_FRAC_EXT = 4'hB;
  localparam logic [3:0] CODE_FASTLOCK = 4'hD;
  localparam logic [3:0] CODE_ACCESS   = 4'hE;

  // field positions
  localparam int AUTO_PU_BIT = 23;
  localparam int RF_PD_BIT   = 5;
  localparam int IF_PD_BIT   = 4;
  localparam int ACCESS_BIT  = 5;
  localparam int NUM_LO_LSB  = 4;
  localparam int DEN_LO_LSB  = 4;
  localparam int EXT_DEN_LSB = 14;
  localparam int EXT_NUM_LSB = 4;
  localparam int FL_LSB      = 4;

  // reset values
  localparam logic             PD_RESET   = 1'b1;
  localparam logic             AUTO_PU_RESET = 1'b0;
  localparam logic             WIDE_RESET = 1'b0;
  localparam logic [LO_W-1:0]  LO_RESET   = 12'h000;
  localparam logic [EXT_W-1:0] EXT_RESET  = 10'h000;

  // fastlock word fields, bits 23:4
  typedef struct packed {
    logic [1:0]  cycle_slip_reducer;
    logic [3:0]  rf_fastlock_pump_current;
    logic [13:0] rf_fastlock_timeout;
  } sfx_fastlock_type;

  localparam sfx_fastlock_type FL_RESET = 20'h00000;

  // fraction seen by the modulator
  typedef struct packed {
    logic              wide_mode;
    logic [FRAC_W-1:0] numerator;
    logic [FRAC_W-1:0] denominator;
  } sfx_frac_type;

endpackage

/* verilog/sfx_serial_rx.sv */
// sfx_serial_rx: three-wire serial word receiver.
// assumes serial pins already synchronous to clk; msb first, latch rising edge ends word.
`timescale 1ns/1ps
module sfx_serial_rx
  import sfx_pkg::*;
#(
  parameter int WIDTH = WORD_W
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // serial pins
  input  wire logic             ser_clk,
  input  wire logic             ser_data,
  input  wire logic             ser_latch,
  // received word
  output logic [WIDTH-1:0]      word,
  output logic                  word_valid
);

  logic             clk_prev_reg;
  logic             latch_prev_reg;
  logic [WIDTH-1:0] shift_reg;

  // edge history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_reg   <= 1'b0;
      latch_prev_reg <= 1'b0;
    end else begin
      clk_prev_reg   <= ser_clk;
      latch_prev_reg <= ser_latch;
    end
  end

  // shift on serial clock rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= '0;
    end else if (ser_clk && !clk_prev_reg) begin
      shift_reg <= {shift_reg[WIDTH-2:0], ser_data};
    end
  end

  // word out on latch rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word       <= '0;
      word_valid <= 1'b0;
    end else begin
      word_valid <= ser_latch && !latch_prev_reg;
      if (ser_latch && !latch_prev_reg) begin
        word <= shift_reg;
      end
    end
  end

endmodule // sfx_serial_rx

/* verilog/sfx_regs.sv */
// sfx_regs: serial programming register bank for fraction extension,
// fastlock control and automatic power-up.
// assumes a host writing 24-bit words on three serial pins synchronous to clk.
`timescale 1ns/1ps
module sfx_regs
  import sfx_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // serial programming pins and device enable pin
  input  wire logic             ser_clk,
  input  wire logic             ser_data,
  input  wire logic             ser_latch,
  input  wire logic             device_enable_pin,
  // power control
  output logic                  rf_power_down,
  output logic                  if_power_down,
  output logic                  auto_power_up,
  // fraction to modulator
  output sfx_frac_type          frac,
  // fastlock control
  output sfx_fastlock_type      fastlock
);

  logic                rst_meta_reg;
  logic                rst_n_sync;
  logic [WORD_W-1:0]   word;
  logic                word_valid;
  logic [CODE_W-1:0]   code;
  logic                main_wr;
  logic                auto_pu;
  logic [LO_W-1:0]     num_lo_reg;
  logic [LO_W-1:0]     den_lo_reg;
  logic [EXT_W-1:0]    ext_num_reg;
  logic [EXT_W-1:0]    ext_den_reg;
  logic                wide_reg;

  // reset release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n_sync   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_sync   <= rst_meta_reg;
    end
  end

  sfx_serial_rx #(
    .WIDTH      (WORD_W)
  ) u_rx (
    .clk        (clk),
    .rst_n      (rst_n_sync),
    .ser_clk    (ser_clk),
    .ser_data   (ser_data),
    .ser_latch  (ser_latch),
    .word       (word),
    .word_valid (word_valid)
  );

  assign code    = word[CODE_W-1:0];
  assign main_wr = word_valid && (code == CODE_MAIN);
  assign auto_pu = main_wr && auto_power_up && device_enable_pin;

  // auto power-up enable
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      auto_power_up <= AUTO_PU_RESET;
    end else if (word_valid && (code == CODE_CFG)) begin
      auto_power_up <= word[AUTO_PU_BIT];
    end
  end

  // power-down bits
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      rf_power_down <= PD_RESET;
      if_power_down <= PD_RESET;
    end else if (auto_pu) begin
      rf_power_down <= 1'b0;
      if_power_down <= 1'b0;
    end else if (word_valid && (code == CODE_PWR)) begin
      rf_power_down <= word[RF_PD_BIT];
      if_power_down <= word[IF_PD_BIT];
    end
  end

  // low fraction words
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      num_lo_reg <= LO_RESET;
      den_lo_reg <= LO_RESET;
    end else begin
      if (main_wr) begin
        num_lo_reg <= word[NUM_LO_LSB +: LO_W];
      end
      if (word_valid && (code == CODE_DEN_LO)) begin
        den_lo_reg <= word[DEN_LO_LSB +: LO_W];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      ext_num_reg <= EXT_RESET;
      ext_den_reg <= EXT_RESET;
    end else if (word_valid && (code == CODE_FRAC_EXT)) begin
      ext_den_reg <= word[EXT_DEN_LSB +: EXT_W];
      ext_num_reg <= word[EXT_NUM_LSB +: EXT_W];
    end
  end

  // width select
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      wide_reg <= WIDE_RESET;
    end else if (word_valid && (code == CODE_ACCESS)) begin
      wide_reg <= word[ACCESS_BIT];
    end
  end

  // fraction forming
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      frac <= '0;
    end else begin
      frac.wide_mode <= wide_reg;
      if (wide_reg) begin
        frac.numerator   <= {ext_num_reg, num_lo_reg};
        frac.denominator <= {ext_den_reg, den_lo_reg};
      end else begin
        frac.numerator   <= {{EXT_W{1'b0}}, num_lo_reg};
        frac.denominator <= {{EXT_W{1'b0}}, den_lo_reg};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      fastlock <= FL_RESET;
    end else if (word_valid && (code == CODE_FASTLOCK)) begin
      fastlock <= sfx_fastlock_type'(word[WORD_W-1:FL_LSB]);
    end
  end

  // checks
  sequence s_main_write_auto;
    word_valid && (code == CODE_MAIN) && auto_power_up && device_enable_pin;
  endsequence

  sequence s_main_write_blocked;
    word_valid && (code == CODE_MAIN) && !device_enable_pin;
  endsequence

  property p_auto_powers_up;
    @(posedge clk) disable iff (!rst_n_sync)
      s_main_write_auto |=> !rf_power_down ##0 !if_power_down;
  endproperty

  chk_auto_rf_up: assert property (p_auto_powers_up)
    else $error("auto power-up did not power up");

  chk_auto_if_up: assert property (@(posedge clk) disable iff (!rst_n_sync)
    s_main_write_auto |=> !if_power_down)
    else $error("auto power-up left IF section down");

  chk_auto_pd_clear: assert property (@(posedge clk) disable iff (!rst_n_sync)
    s_main_write_auto |=> (rf_power_down == 1'b0) && (if_power_down == 1'b0)
                          && $fell(rf_power_down) == $past(rf_power_down))
    else $error("power-down bits not cleared");

  chk_enable_low_hold: assert property (@(posedge clk) disable iff (!rst_n_sync)
    s_main_write_blocked |=> $stable(rf_power_down) && $stable(if_power_down))
    else $error("auto power-up acted with enable low");

  chk_narrow_num: assert property (@(posedge clk) disable iff (!rst_n_sync)
    !wide_reg |=> frac.numerator == {{EXT_W{1'b0}}, $past(num_lo_reg)})
    else $error("narrow numerator used upper bits");

  chk_wide_num: assert property (@(posedge clk) disable iff (!rst_n_sync)
    wide_reg |=> frac.numerator == {$past(ext_num_reg), $past(num_lo_reg)})
    else $error("wide numerator wrong");

  chk_narrow_den: assert property (@(posedge clk) disable iff (!rst_n_sync)
    !wide_reg |=> frac.denominator == {{EXT_W{1'b0}}, $past(den_lo_reg)})
    else $error("narrow denominator used upper bits");

  chk_wide_den: assert property (@(posedge clk) disable iff (!rst_n_sync)
    wide_reg |=> frac.denominator == {$past(ext_den_reg), $past(den_lo_reg)})
    else $error("wide denominator wrong");

  chk_ext_decode: assert property (@(posedge clk) disable iff (!rst_n_sync)
    word_valid && (code == CODE_FRAC_EXT) |-> ##2
      frac.numerator[FRAC_W-1:LO_W] == ($past(wide_reg) ? $past(word[13:4], 2) : 10'h000))
    else $error("extension word not decoded");

  chk_ext_den_decode: assert property (@(posedge clk) disable iff (!rst_n_sync)
    word_valid && (code == CODE_FRAC_EXT) |-> ##2
      frac.denominator[FRAC_W-1:LO_W] == ($past(wide_reg) ? $past(word[23:14], 2) : 10'h000))
    else $error("extension denominator not decoded");

  chk_fastlock_decode: assert property (@(posedge clk) disable iff (!rst_n_sync)
    word_valid && (code == CODE_FASTLOCK) |=>
      fastlock.cycle_slip_reducer == $past(word[23:22])
      && fastlock.rf_fastlock_pump_current == $past(word[21:18])
      && fastlock.rf_fastlock_timeout == $past(word[17:4]))
    else $error("fastlock word not decoded");

endmodule // sfx_regs

/* tb/sfx_host_model.sv */
// sfx_host_model: host side of the three-wire serial programming link.
// assumes the device samples the pins on clk; each level is held two cycles.
`timescale 1ns/1ps
module sfx_host_model (
  // clock
  input  wire logic clk,
  // serial pins
  output logic      ser_clk,
  output logic      ser_data,
  output logic      ser_latch
);
  initial begin
    ser_clk   = 1'b0;
    ser_data  = 1'b0;
    ser_latch = 1'b0;
  end

  task automatic hold2();
    repeat (2) @(posedge clk);
    #1;
  endtask

  // one word, msb first; clock idles low between frames
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      ser_data = w[i];
      hold2();
      ser_clk = 1'b1;
      hold2();
      ser_clk = 1'b0;
    end
    ser_latch = 1'b1;
    hold2();
    ser_latch = 1'b0;
    // released data line shows no stale bit
    ser_data = ~w[0];
    hold2();
  endtask
endmodule // sfx_host_model

/* tb/test_sfx_regs.sv */
// test_sfx_regs: random serial words against an integer model of the bank.
// assumes sfx_regs and sfx_host_model; one 125 MHz clock.
`timescale 1ns/1ps
module test_sfx_regs;
  import sfx_pkg::*;
  logic             clk;
  logic             nrst;
  logic             device_enable_pin;
  logic             ser_clk;
  logic             ser_data;
  logic             ser_latch;
  logic             rf_power_down;
  logic             if_power_down;
  logic             auto_power_up;
  sfx_frac_type     frac;
  sfx_fastlock_type fastlock;
  int               errors = 0;
  int               n_checks = 0;
  int               seed = 82;
  int               nl = 0, dl = 0, nh = 0, dh = 0, wide = 0, auto_en = 0, fl = 0;
  int               pdr = 1, pdi = 1;
  logic [23:0]      w;
  logic [3:0]       codes [0:7] = '{CODE_MAIN, CODE_DEN_LO, CODE_PWR, CODE_CFG,
                                    CODE_FRAC_EXT, CODE_FASTLOCK, CODE_ACCESS, 4'h5};

  sfx_regs i_sfx_regs (
    .clk               (clk),
    .nrst              (nrst),
    .ser_clk           (ser_clk),
    .ser_data          (ser_data),
    .ser_latch         (ser_latch),
    .device_enable_pin (device_enable_pin),
    .rf_power_down     (rf_power_down),
    .if_power_down     (if_power_down),
    .auto_power_up     (auto_power_up),
    .frac              (frac),
    .fastlock          (fastlock)
  );

  sfx_host_model i_sfx_host_model (
    .clk       (clk),
    .ser_clk   (ser_clk),
    .ser_data  (ser_data),
    .ser_latch (ser_latch)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk_frac(input logic [44:0] exp);
    n_checks++;
    if (frac !== exp) begin
      errors++;
      $display("wrong value frac expected %h seen %h", exp, frac);
    end
  endtask

  task automatic chk_power(input logic [2:0] exp);
    n_checks++;
    if ({rf_power_down, if_power_down, auto_power_up} !== exp) begin
      errors++;
      $display("wrong value power expected %h seen %h", exp,
               {rf_power_down, if_power_down, auto_power_up});
    end
  endtask

  task automatic chk_fastlock(input logic [19:0] exp);
    n_checks++;
    if (fastlock !== exp) begin
      errors++;
      $display("wrong value fastlock expected %h seen %h", exp, fastlock);
    end
  endtask

  task automatic report_and_stop();
    if (errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // model of one decoded word
  task automatic model(input logic [23:0] v);
    case (v[3:0])
      CODE_MAIN: begin
        nl = v[15:4];
        if (auto_en[0] && device_enable_pin) begin
          pdr = 0;
          pdi = 0;
        end
      end
      CODE_DEN_LO: dl = v[15:4];
      CODE_PWR: begin
        pdr = v[5];
        pdi = v[4];
      end
      CODE_CFG: auto_en = v[23];
      CODE_FRAC_EXT: begin
        dh = v[23:14];
        nh = v[13:4];
      end
      CODE_FASTLOCK: fl = v[23:4];
      CODE_ACCESS: wide = v[5];
      default: ;
    endcase
  endtask

  task automatic check_all();
    logic [21:0] en;
    logic [21:0] ed;
    en = wide[0] ? {nh[9:0], nl[11:0]} : {10'h000, nl[11:0]};
    ed = wide[0] ? {dh[9:0], dl[11:0]} : {10'h000, dl[11:0]};
    chk_frac({wide[0], en, ed});
    chk_power({pdr[0], pdi[0], auto_en[0]});
    chk_fastlock(fl[19:0]);
  endtask

  initial begin
    nrst = 1'b0;
    device_enable_pin = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check_all();
    for (int k = 0; k < 80; k++) begin
      w = 24'($random(seed));
      w[3:0] = codes[{$random(seed)} % 8];
      if (w[3:0] == CODE_FRAC_EXT && k[0]) w[23:4] = 20'h00000;
      device_enable_pin = ($random(seed) & 3) != 0;
      i_sfx_host_model.send(w);
      model(w);
      check_all();
    end
    report_and_stop();
  end

  // watchdog, about two and a half times the expected run
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    report_and_stop();
  end
endmodule // test_sfx_regs
